/* File: core/emdio_pkg.sv */
package emdio_pkg;

  // Timing: the management clock is never faster than 2.5 MHz
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned MDC_MIN_PERIOD_NS = 400;
  localparam int unsigned MDC_MIN_CYCLES    =
    (MDC_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Frame layout
  localparam logic [5:0] PRE_LEN   = 6'h20;
  localparam logic [3:0] HDR_LAST  = 4'hb;
  localparam logic [3:0] DATA_LAST = 4'hf;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam int         HDR_OP_HI = 11;
  localparam int         HDR_CLAIM = 9;
  localparam int         KEY_HI    = 8;
  localparam int         KEY_LO    = 1;
  localparam int         HALF_BIT  = 0;

  // Widths and system address packing
  localparam int         KEY_W     = 8;
  localparam int         ADDR_W    = 10;
  localparam int         HALF_W    = 16;
  localparam int         WORD_W    = 32;
  localparam logic [1:0] ADDR_PAD  = 2'h0;

  // Strap handling
  localparam logic [1:0] MODE_EXT   = 2'h1;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [3:0] {
    ST_PRE, ST_START, ST_HDR, ST_RD_TA, ST_RD_DATA, ST_RD_END, ST_WR_TA, ST_WR_DATA
  } emdio_state_t;

  function automatic logic [HALF_W-1:0] emdio_pick_half(input logic [WORD_W-1:0] word,
                                                        input logic              half);
    emdio_pick_half = half ? word[WORD_W-1:HALF_W] : word[HALF_W-1:0];
  endfunction : emdio_pick_half

endpackage : emdio_pkg

/* File: core/emdio_wr_if.sv */
`timescale 1ns/1ps
interface emdio_wr_if;
  import emdio_pkg::*;

  logic              evt;
  logic              half;
  logic [KEY_W-1:0]  key;
  logic [HALF_W-1:0] word;
  logic              clr;

  modport src  (output evt, output half, output key, output word, output clr);
  modport sink (input evt, input half, input key, input word, input clr);

endinterface : emdio_wr_if

/* File: core/emdio_sync.sv */
`timescale 1ns/1ps
module emdio_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : emdio_sync

/* File: core/emdio_wr_pair.sv */
`timescale 1ns/1ps
module emdio_wr_pair (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  emdio_wr_if.sink                           wr,
  output logic                               reg_wr,
  output logic     [emdio_pkg::WORD_W-1:0]   reg_wdata
);
  import emdio_pkg::*;

  logic              pend;
  logic              pend_half;
  logic [KEY_W-1:0]  pend_key;
  logic [HALF_W-1:0] hold;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend      <= 1'h0;
      pend_half <= 1'h0;
      pend_key  <= '0;
      hold      <= '0;
      reg_wr    <= 1'h0;
      reg_wdata <= '0;
    end else begin
      reg_wr <= 1'h0;
      if (wr.clr) begin
        pend <= 1'h0;
      end else if (wr.evt) begin
        if (pend && (wr.key == pend_key) && (wr.half != pend_half)) begin
          reg_wdata <= wr.half ? {wr.word, hold} : {hold, wr.word};
          reg_wr    <= 1'h1;
          pend      <= 1'h0;
        end else if (pend && (wr.key == pend_key)) begin
          // Repeat of the held half: dropped, the first half stays waiting
          pend <= 1'h1;
        end else begin
          pend      <= 1'h1;
          pend_half <= wr.half;
          pend_key  <= wr.key;
          hold      <= wr.word;
        end
      end
    end
  end

endmodule : emdio_wr_pair

/* File: core/emdio_slave_top.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module emdio_slave_top (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          mdc,
  input  wire logic                          mdio_in,
  output logic                               mdio_out,
  output logic                               mdio_oe,
  input  wire logic [1:0]                    mngt_mode_strap,
  output logic                               mngt_ext_active,
  output logic     [emdio_pkg::ADDR_W-1:0]   reg_addr,
  output logic                               reg_rd_req,
  input  wire logic [emdio_pkg::WORD_W-1:0]  reg_rdata,
  input  wire logic                          reg_hit,
  input  wire logic                          reg_rd16,
  output logic                               reg_rd_done,
  output logic                               reg_wr,
  output logic     [emdio_pkg::WORD_W-1:0]   reg_wdata
);
  import emdio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and MDC edge detection

  logic [1:0]        strap_s;
  logic              mdc_s;
  logic              mdio_s;
  logic              mdc_prev;
  logic              bit_tick;

  // Straps ride the same synchroniser; the value kept is the one read once it settles
  emdio_sync #(
    .W (4)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({mngt_mode_strap, mdc, mdio_in}),
    .q       ({strap_s, mdc_s, mdio_s})
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_prev <= 1'h0;
    end else begin
      mdc_prev <= mdc_s;
    end
  end

  // MDC runs at most at a quarter of clk, so every edge is seen
  assign bit_tick = mdc_s & ~mdc_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode strap, taken once the synchroniser has settled after reset

  // Frozen once the wait ends: the straps are boot-time pins
  logic [1:0]        strap_wait;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_wait      <= 2'h0;
      mngt_ext_active <= 1'h0;
    end else if (strap_wait != STRAP_WAIT) begin
      strap_wait      <= strap_wait + 2'h1;
      mngt_ext_active <= (strap_s == MODE_EXT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame decoder

  emdio_state_t      state;
  logic [5:0]        pre_cnt;
  logic [10:0]       hdr;
  logic [3:0]        bit_cnt;
  logic              ta_seen;
  logic [11:0]       hdr_full;
  logic              hdr_claim;
  logic              hdr_done;
  logic              rd_go;
  logic              wr_go;
  logic              wr_last;
  logic              rd_last;

  // Header shifts in msb first; its last bit comes straight from the pin
  assign hdr_full  = {hdr, mdio_s};
  assign hdr_claim = mngt_ext_active & hdr_full[HDR_CLAIM];
  assign hdr_done  = bit_tick && (state == ST_HDR) && (bit_cnt == HDR_LAST);
  assign rd_go     = hdr_done && hdr_claim && (hdr_full[HDR_OP_HI -: 2] == OP_READ);
  assign wr_go     = hdr_done && hdr_claim && (hdr_full[HDR_OP_HI -: 2] == OP_WRITE);
  assign wr_last   = bit_tick && (state == ST_WR_DATA) && (bit_cnt == 4'h0);
  assign rd_last   = bit_tick && (state == ST_RD_END);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state   <= ST_PRE;
      pre_cnt <= 6'h00;
      hdr     <= '0;
      bit_cnt <= 4'h0;
      ta_seen <= 1'h0;
    end else if (bit_tick) begin
      unique case (state)
        ST_PRE: begin
          if (mdio_s) begin
            // Saturate so a preamble longer than the minimum still counts
            if (pre_cnt != PRE_LEN) begin
              pre_cnt <= pre_cnt + 6'h01;
            end
          end else if (pre_cnt == PRE_LEN) begin
            state   <= ST_START;
            pre_cnt <= 6'h00;
          end else begin
            pre_cnt <= 6'h00;
          end
        end
        ST_START: begin
          if (mdio_s) begin
            state   <= ST_HDR;
            bit_cnt <= 4'h0;
          end else begin
            state <= ST_PRE;
          end
        end
        ST_HDR: begin
          hdr     <= hdr_full[10:0];
          ta_seen <= 1'h0;
          if (bit_cnt == HDR_LAST) begin
            if (rd_go) begin
              state <= ST_RD_TA;
            end else if (wr_go) begin
              state <= ST_WR_TA;
            end else begin
              // Foreign PHY address, bad opcode or mode off
              state <= ST_PRE;
            end
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        ST_RD_TA: begin
          if (ta_seen) begin
            state   <= ST_RD_DATA;
            bit_cnt <= DATA_LAST;
          end else begin
            ta_seen <= 1'h1;
          end
        end
        ST_RD_DATA: begin
          if (bit_cnt == 4'h0) begin
            state <= ST_RD_END;
          end else begin
            bit_cnt <= bit_cnt - 4'h1;
          end
        end
        ST_RD_END: begin
          // Extra edge on which the driver lets go of MDIO
          state <= ST_PRE;
        end
        ST_WR_TA: begin
          // Turnaround content is not checked; the host owns the line here
          if (ta_seen) begin
            state   <= ST_WR_DATA;
            bit_cnt <= DATA_LAST;
          end else begin
            ta_seen <= 1'h1;
          end
        end
        ST_WR_DATA: begin
          if (bit_cnt == 4'h0) begin
            state <= ST_PRE;
          end else begin
            bit_cnt <= bit_cnt - 4'h1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Current frame address and system request

  logic              cur_half;
  logic [KEY_W-1:0]  cur_key;
  logic              rd_cap;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_half   <= 1'h0;
      cur_key    <= '0;
      reg_addr   <= '0;
      reg_rd_req <= 1'h0;
      rd_cap     <= 1'h0;
    end else begin
      reg_rd_req <= rd_go;
      rd_cap     <= rd_go;
      if (rd_go || wr_go) begin
        cur_half <= hdr_full[HALF_BIT];
        cur_key  <= hdr_full[KEY_HI:KEY_LO];
        reg_addr <= {hdr_full[KEY_HI:KEY_LO], ADDR_PAD};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read pairing, capture and deferred side effects

  logic              rd_pend;
  logic              pend_half;
  logic [KEY_W-1:0]  pend_key;
  logic [WORD_W-1:0] rd_hold;
  logic [HALF_W-1:0] out_sh;
  logic              done_due;
  logic              rd_second;
  logic [WORD_W-1:0] rd_word;

  assign rd_second = rd_pend && (cur_key == pend_key) && (cur_half != pend_half);
  // Unmapped addresses still answer, with driven zeros
  assign rd_word   = reg_hit ? reg_rdata : '0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend   <= 1'h0;
      pend_half <= 1'h0;
      pend_key  <= '0;
      rd_hold   <= '0;
      out_sh    <= '0;
      done_due  <= 1'h0;
    end else if (rd_cap) begin
      if (rd_second) begin
        out_sh   <= emdio_pick_half(rd_hold, cur_half);
        rd_pend  <= 1'h0;
        done_due <= 1'h1;
      end else begin
        // Fresh pair; a same-half repeat lands here and restarts pairing
        rd_hold   <= rd_word;
        out_sh    <= emdio_pick_half(rd_word, cur_half);
        rd_pend   <= ~reg_rd16;
        pend_half <= cur_half;
        pend_key  <= cur_key;
        done_due  <= reg_rd16 & reg_hit;
      end
    end else if (wr_go) begin
      // An unfinished read pair leaves the register untouched
      rd_pend <= 1'h0;
    end else if (bit_tick && (state == ST_RD_DATA)) begin
      out_sh <= {out_sh[HALF_W-2:0], 1'h0};
    end else if (rd_last) begin
      done_due <= 1'h0;
    end
  end

  // Side effects wait until the line is released after the last bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rd_done <= 1'h0;
    end else begin
      reg_rd_done <= rd_last & done_due;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // MDIO driver
  // Bits change only on a seen MDC rise, never between edges

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdio_out <= 1'h0;
      mdio_oe  <= 1'h0;
    end else if (bit_tick) begin
      unique case (state)
        ST_RD_TA: begin
          // First turnaround edge floats, second drives the zero
          if (ta_seen) begin
            mdio_out <= 1'h0;
            mdio_oe  <= 1'h1;
          end
        end
        ST_RD_DATA: begin
          mdio_out <= out_sh[HALF_W-1];
          mdio_oe  <= 1'h1;
        end
        default: begin
          mdio_oe <= 1'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write path

  // Write data never reaches the driver; only the pair logic sees it
  logic [HALF_W-1:0] wdata_sh;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdata_sh <= '0;
    end else if (bit_tick && (state == ST_WR_DATA)) begin
      wdata_sh <= {wdata_sh[HALF_W-2:0], mdio_s};
    end
  end

  emdio_wr_if wr_bus ();

  assign wr_bus.evt  = wr_last;
  assign wr_bus.half = cur_half;
  assign wr_bus.key  = cur_key;
  assign wr_bus.word = {wdata_sh[HALF_W-2:0], mdio_s};
  // A read between two write halves breaks the write pair
  assign wr_bus.clr  = rd_go;

  emdio_wr_pair u_wr_pair (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .wr        (wr_bus.sink),
    .reg_wr    (reg_wr),
    .reg_wdata (reg_wdata)
  );

endmodule : emdio_slave_top

/* File: tb/emdio_slave_checker.sv */
`timescale 1ns/1ps
module emdio_slave_checker (
  input wire logic                         clk,
  input wire logic                         sys_rst,
  input wire logic                         mdc,
  input wire logic                         mdio_out,
  input wire logic                         mdio_oe,
  input wire logic [1:0]                   mngt_mode_strap,
  input wire logic                         mngt_ext_active,
  input wire logic [emdio_pkg::ADDR_W-1:0] reg_addr,
  input wire logic                         reg_rd_req,
  input wire logic                         reg_rd_done,
  input wire logic                         reg_wr
);
  import emdio_pkg::*;
  logic       mdc_q;
  logic [3:0] since;
  logic [4:0] oe_rises;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) mdc_q <= 1'b0;
    else mdc_q <= mdc;
  end
  // Raw MDC edges; the design sees them a few clocks later
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) since <= 4'hf;
    else if (mdc && !mdc_q) since <= 4'h0;
    else if (since != 4'hf) since <= since + 4'h1;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) oe_rises <= 5'h0;
    else if (!mdio_oe) oe_rises <= 5'h0;
    else if (mdc && !mdc_q) oe_rises <= oe_rises + 5'h1;
  end
  //////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_ext_mode;
    $stable(mngt_mode_strap) [*5] |-> mngt_ext_active == (mngt_mode_strap == MODE_EXT);
  endproperty
  property p_no_ext;
    !mngt_ext_active |-> !mdio_oe && !reg_rd_req && !reg_wr;
  endproperty
  property p_drive_edge;
    $changed(mdio_oe) || (mdio_oe && $changed(mdio_out)) |-> since <= 4'h6;
  endproperty
  property p_ta_low;
    $rose(mdio_oe) |-> !mdio_out;
  endproperty
  property p_drive_len;
    $fell(mdio_oe) |-> oe_rises == 5'h11;
  endproperty
  property p_req_first;
    reg_rd_req |-> !mdio_oe ##[1:40] $rose(mdio_oe);
  endproperty
  property p_req_pulse;
    reg_rd_req |=> !reg_rd_req;
  endproperty
  property p_done_after;
    reg_rd_done |-> !mdio_oe && ($past(mdio_oe) || $past(mdio_oe, 2) || $past(mdio_oe, 3));
  endproperty
  property p_done_pulse;
    reg_rd_done |=> !reg_rd_done;
  endproperty
  property p_wr_quiet;
    reg_wr |-> !mdio_oe ##1 !reg_wr;
  endproperty
  property p_addr_hold;
    mdio_oe |-> $stable(reg_addr);
  endproperty

  a_ext_mode: assert property (p_ext_mode) else $error("mode flag wrong");
  a_no_ext: assert property (p_no_ext) else $error("activity while off");
  a_drive_edge: assert property (p_drive_edge) else $error("drive off edge");
  a_ta_low: assert property (p_ta_low) else $error("turnaround not low");
  a_drive_len: assert property (p_drive_len) else $error("drive length");
  a_req_first: assert property (p_req_first) else $error("no drive after req");
  a_req_pulse: assert property (p_req_pulse) else $error("req too long");
  a_done_after: assert property (p_done_after) else $error("done timing");
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  a_wr_quiet: assert property (p_wr_quiet) else $error("write pulse");
  a_addr_hold: assert property (p_addr_hold) else $error("addr moved");

  c_wr: cover property (reg_wr);
  c_done: cover property (reg_rd_done);
  c_read: cover property ($fell(mdio_oe));
endmodule : emdio_slave_checker

bind emdio_slave_top emdio_slave_checker emdio_slave_checker_inst (.clk, .sys_rst, .mdc,
  .mdio_out, .mdio_oe, .mngt_mode_strap, .mngt_ext_active, .reg_addr, .reg_rd_req,
  .reg_rd_done, .reg_wr);

/* File: tb/emdio_host_model.sv */
`timescale 1ns/1ps
module emdio_host_model (
  input  wire logic clk,
  input  wire logic mdio,
  output logic      mdc,
  output logic      host_oe,
  output logic      host_out
);
  import emdio_pkg::*;
  initial begin
    mdc = 1'b0;
    host_oe = 1'b0;
    host_out = 1'b0;
  end
  // One frame, 800 ns per bit; MDC stands low between frames.
  // smp keeps the wire level just before each of the last 18 rising edges.
  task automatic frame(input int pre, input logic [1:0] st, input logic [1:0] op,
                       input logic [9:0] adr, input logic [15:0] wd,
                       output logic [17:0] smp);
    logic [31:0] v;
    v = {st, op, adr, 2'h2, wd};
    smp = '0;
    for (int i = 0; i <= pre + 32; i++) begin
      @(posedge clk);
      mdc <= 1'b0;
      host_oe <= (i < pre + 14) || (op == OP_WRITE && i < pre + 32);
      host_out <= (i < pre) ? 1'b1 : v[31];
      if (i >= pre) v = v << 1;
      repeat (4) @(posedge clk);
      smp = {smp[16:0], mdio};
      mdc <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    mdc <= 1'b0;
    host_oe <= 1'b0;
  endtask : frame
endmodule : emdio_host_model

/* File: tb/emdio_slave_tb_top.sv */
`timescale 1ns/1ps
module emdio_slave_tb_top;
  import emdio_pkg::*;
  localparam logic [ADDR_W-1:0] A_P      = 10'h2a8;
  localparam logic [ADDR_W-1:0] A_CNT    = 10'h040;
  localparam logic [ADDR_W-1:0] A_COR    = 10'h080;
  localparam logic [ADDR_W-1:0] A_R16    = 10'h104;
  localparam logic [ADDR_W-1:0] A_U      = 10'h3c8;
  localparam logic [WORD_W-1:0] COR_INIT = 32'h5a5a0f0f;
  localparam int                LIMIT    = 30000;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [1:0]        mngt_mode_strap = MODE_EXT;
  logic              mdc, host_oe, host_out, mdio, mdio_out, mdio_oe, mngt_ext_active;
  logic              reg_rd_req, reg_hit, reg_rd16, reg_rd_done, reg_wr;
  logic              oe_seen = 1'b0;
  logic [ADDR_W-1:0] reg_addr, wr_addr;
  logic [WORD_W-1:0] reg_rdata, reg_wdata, req_val;
  logic [WORD_W-1:0] tick = '0;
  logic [WORD_W-1:0] cor = COR_INIT;
  logic [17:0]       s;
  int n_errors = 0, samples_checked = 0, n_done = 0, n_wr = 0, n_req = 0, cyc = 0;

  function automatic logic [WORD_W-1:0] pat(input logic [ADDR_W-1:0] a);
    return {6'h2a, a, 6'h15, a};
  endfunction : pat
  function automatic logic [9:0] key(input logic [ADDR_W-1:0] a, input logic h);
    return {1'b1, a[9:6], a[5:2], h};
  endfunction : key

  always #50 clk = ~clk;
  // Pull-up wins when nobody drives
  assign mdio = mdio_oe ? mdio_out : (host_oe ? host_out : 1'b1);
  // Unmapped space answers garbage so zeros must come from the slave
  assign reg_hit = reg_addr[9:6] != 4'hf;
  assign reg_rd16 = reg_addr[5:2] == 4'h1;
  // Counter copies its fast low half upward so a second latch would show
  assign reg_rdata = !reg_hit ? 32'hdeadbeef :
                     (reg_addr == A_CNT) ? {tick[15:0], tick[15:0]} :
                     (reg_addr == A_COR) ? cor : pat(reg_addr);

  always @(posedge clk) begin
    tick <= tick + 32'h1;
    cyc <= cyc + 1;
    if (mdio_oe === 1'b1) oe_seen <= 1'b1;
    if (reg_rd_req === 1'b1) req_val <= reg_rdata;
    if (reg_rd_req === 1'b1) n_req <= n_req + 1;
    if (reg_rd_done === 1'b1) n_done <= n_done + 1;
    if (reg_rd_done === 1'b1 && reg_addr == A_COR) cor <= '0;
    if (reg_wr === 1'b1) n_wr <= n_wr + 1;
    if (reg_wr === 1'b1) wr_addr <= reg_addr;
    if (cyc == LIMIT) begin
      n_errors++;
      end_sim();
    end
  end

  emdio_slave_top emdio_slave_top_inst (.clk, .sys_rst, .mdc, .mdio_in(mdio), .mdio_out,
    .mdio_oe, .mngt_mode_strap, .mngt_ext_active, .reg_addr, .reg_rd_req, .reg_rdata,
    .reg_hit, .reg_rd16, .reg_rd_done, .reg_wr, .reg_wdata);
  emdio_host_model emdio_host_model_inst (.clk, .mdio, .mdc, .host_oe, .host_out);
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic do_reset(input logic [1:0] m);
    sys_rst <= 1'b1;
    mngt_mode_strap <= m;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : do_reset
  task automatic rd(input logic [ADDR_W-1:0] a, input logic h);
    emdio_host_model_inst.frame(32, 2'h1, OP_READ, key(a, h), 16'h0, s);
    repeat (8) @(posedge clk);
    chk(s[17:16], 2'h2);
  endtask : rd
  task automatic wr(input logic [ADDR_W-1:0] a, input logic h, input logic [15:0] d);
    oe_seen <= 1'b0;
    emdio_host_model_inst.frame(32, 2'h1, OP_WRITE, key(a, h), d, s);
    repeat (8) @(posedge clk);
    chk(oe_seen, 1'b0);
  endtask : wr
  //////////////////////////////////////////////////
  task automatic t_pair;
    int n0;
    logic [15:0] h;
    logic [WORD_W-1:0] exp;
    n0 = n_done;
    // First access after reset reads the fixed pattern, as a host polls it
    rd(A_P, 1'b1);
    h = s[15:0];
    chk(n_done, n0);
    rd(A_P, 1'b0);
    chk({h, s[15:0]}, pat(A_P));
    chk(n_done, n0 + 1);
    rd(A_CNT, 1'b0);
    exp = req_val;
    h = s[15:0];
    rd(A_CNT, 1'b1);
    chk({s[15:0], h}, exp);
  endtask : t_pair
  task automatic t_cor;
    logic [15:0] h;
    rd(A_COR, 1'b0);
    rd(A_P, 1'b1);
    rd(A_P, 1'b0);
    chk(cor, COR_INIT);
    rd(A_COR, 1'b1);
    h = s[15:0];
    rd(A_COR, 1'b0);
    chk({h, s[15:0]}, COR_INIT);
    chk(cor, 32'h0);
  endtask : t_cor
  task automatic t_same;
    int n0;
    n0 = n_done;
    rd(A_P, 1'b0);
    rd(A_P, 1'b0);
    chk(n_done, n0);
    rd(A_P, 1'b1);
    chk(n_done, n0 + 1);
    rd(A_R16, 1'b0);
    chk(s[15:0], pat(A_R16) & 32'h0000ffff);
    chk(n_done, n0 + 2);
    rd(A_U, 1'b1);
    chk(s[15:0], 16'h0);
  endtask : t_same
  // Writes go to implemented places only; last data ends in 0 for the short preamble
  task automatic t_write;
    int w0;
    w0 = n_wr;
    wr(A_P, 1'b0, 16'h1234);
    wr(A_P, 1'b0, 16'h5678);
    chk(n_wr, w0);
    wr(A_P, 1'b1, 16'h9abc);
    chk(n_wr, w0 + 1);
    chk(reg_wdata, 32'h9abc1234);
    chk(wr_addr, A_P);
    wr(A_CNT, 1'b1, 16'hfedc);
    wr(A_CNT, 1'b0, 16'h0002);
    chk(reg_wdata, 32'hfedc0002);
    chk(wr_addr, A_CNT);
  endtask : t_write
  task automatic t_refuse;
    int pre[5] = '{20, 32, 32, 32, 32};
    logic [1:0] st[5] = '{2'h1, 2'h0, 2'h1, 2'h1, 2'h1};
    logic [1:0] op[5] = '{OP_READ, OP_READ, 2'h3, 2'h0, OP_READ};
    int r0;
    for (int i = 0; i < 5; i++) begin
      r0 = n_req;
      oe_seen <= 1'b0;
      emdio_host_model_inst.frame(pre[i], st[i], op[i],
        (i == 4) ? key(A_P, 1'b1) & 10'h1ff : key(A_P, 1'b1), 16'h0, s);
      repeat (8) @(posedge clk);
      chk(n_req, r0);
      chk(oe_seen, 1'b0);
    end
    rd(A_P, 1'b1);
    chk(s[15:0], pat(A_P) >> 16);
  endtask : t_refuse
  task automatic t_reset;
    int n0;
    int r0;
    rd(A_CNT, 1'b0);
    do_reset(2'h0);
    chk(mngt_ext_active, 1'b0);
    r0 = n_req;
    emdio_host_model_inst.frame(32, 2'h1, OP_READ, key(A_P, 1'b1), 16'h0, s);
    repeat (8) @(posedge clk);
    chk(n_req, r0);
    chk(s, 18'h3ffff);
    do_reset(MODE_EXT);
    chk(mngt_ext_active, 1'b1);
    n0 = n_done;
    rd(A_CNT, 1'b1);
    chk(n_done, n0);
    rd(A_CNT, 1'b0);
    chk(n_done, n0 + 1);
  endtask : t_reset

  initial begin
    do_reset(MODE_EXT);
    t_pair();
    t_cor();
    t_same();
    t_write();
    t_refuse();
    t_reset();
    end_sim();
  end
endmodule : emdio_slave_tb_top
